/* rtl/pbr_map.vh */
// Timing and encoding constants for the push-button reset timer.
`ifndef PBR_MAP_VH
`define PBR_MAP_VH
// ----------------------------------------------------------------------------
// Variant encodings
// ----------------------------------------------------------------------------
`define PBR_VAR_LEVEL 2'h0
`define PBR_VAR_DUAL_PULSE 2'h1
`define PBR_VAR_SINGLE 2'h2
// ----------------------------------------------------------------------------
// Times in their own units
// ----------------------------------------------------------------------------
`define PBR_CLK_HZ 50000000
`define PBR_TICK_US 1000
`define PBR_STARTUP_US 300
`define PBR_HOLD_LONG_MS 12500
`define PBR_HOLD_STD_MS 7500
`define PBR_HOLD_ZERO_MS 0
`define PBR_PULSE_MS 400
// ----------------------------------------------------------------------------
// Derived counts
// ----------------------------------------------------------------------------
`define PBR_TICK_CYC ((`PBR_CLK_HZ / 1000000) * `PBR_TICK_US)
`define PBR_STARTUP_CYC ((`PBR_CLK_HZ / 1000000) * `PBR_STARTUP_US)
`define PBR_HOLD_LONG_TK (`PBR_HOLD_LONG_MS * 1000 / `PBR_TICK_US)
`define PBR_HOLD_STD_TK (`PBR_HOLD_STD_MS * 1000 / `PBR_TICK_US)
`define PBR_HOLD_ZERO_TK (`PBR_HOLD_ZERO_MS * 1000 / `PBR_TICK_US)
`define PBR_PULSE_TK (`PBR_PULSE_MS * 1000 / `PBR_TICK_US)
`endif

/* rtl/pbr_startup.v */
// Start-up delay counter after reset release.
`timescale 1ns/1ps
module pbr_startup #(
  parameter CYC = 15000
) (
  input wire sys_clk_i,
  input wire rst_i,
  output reg ready_o
);
  reg [31:0] cnt_r;
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 32'h0000_0000;
      ready_o <= 1'b0;
    end else if (!ready_o) begin
      if (cnt_r >= CYC - 1) begin
        ready_o <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 32'h0000_0001;
      end
    end
  end
endmodule // pbr_startup

/* rtl/pbr_tick.v */
// Divider that makes the one-cycle time base enable.
`timescale 1ns/1ps
module pbr_tick #(
  parameter DIV = 50000
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire run_i,
  output reg tick_o
);
  reg [31:0] cnt_r;
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_r <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else if (cnt_r == DIV - 1) begin
      cnt_r <= 32'h0000_0000;
      tick_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
      tick_o <= 1'b0;
    end
  end
endmodule // pbr_tick

/* rtl/pbr_timer.v */
// Push-button reset timer top level.
`timescale 1ns/1ps
`include "pbr_map.vh"
module pbr_timer #(
  parameter [1:0] VARIANT = `PBR_VAR_LEVEL,
  parameter TICK_CYC = `PBR_TICK_CYC,
  parameter STARTUP_CYC = `PBR_STARTUP_CYC,
  parameter HOLD_HI_TK = `PBR_HOLD_LONG_TK,
  parameter HOLD_LO_TK = `PBR_HOLD_STD_TK,
  parameter HOLD_PHI_TK = `PBR_HOLD_ZERO_TK,
  parameter PULSE_TK = `PBR_PULSE_TK,
  parameter CW = 16
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire first_button_in_n_i,
  input wire second_button_in_n_i,
  input wire delay_select_pin_i,
  output reg rst_out_n_o,
  output reg rst_out_oe_o
);
  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_HOLD = 2'h1;
  localparam [1:0] ST_ASSERT = 2'h2;
  localparam [1:0] ST_WAIT = 2'h3;

  localparam IS_LEVEL = (VARIANT == `PBR_VAR_LEVEL);
  localparam IS_SINGLE = (VARIANT == `PBR_VAR_SINGLE);

  wire ready;
  wire tick;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [CW-1:0] cnt_r;
  reg [CW-1:0] cnt_nxt;
  reg sel_r;
  reg assert_nxt;

  // --------------------------------------------------------------------------
  // Time base and start-up
  // --------------------------------------------------------------------------
  pbr_startup #(.CYC(STARTUP_CYC)) u_startup (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ready_o(ready)
  );

  // The divider restarts at each hold so a hold is never short by a partial tick.
  pbr_tick #(.DIV(TICK_CYC)) u_tick (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .run_i(state_r == ST_HOLD || state_r == ST_ASSERT),
    .tick_o(tick)
  );

  // With one button the second input is not monitored at all.
  wire pressed = IS_SINGLE ? !first_button_in_n_i
                           : (!first_button_in_n_i && !second_button_in_n_i);

  // Hold delay in ticks for the sampled select level.
  function [CW-1:0] hold_len;
    input sel;
    begin
      if (IS_LEVEL) begin
        hold_len = sel ? HOLD_HI_TK[CW-1:0] : HOLD_LO_TK[CW-1:0];
      end else begin
        hold_len = sel ? HOLD_PHI_TK[CW-1:0] : HOLD_LO_TK[CW-1:0];
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Select sampling
  // --------------------------------------------------------------------------
  // The select pin is only trusted at power-up or while a button is up; the
  // system is expected to change it only then.
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_r <= 1'b0;
    end else if (!ready || !pressed) begin
      sel_r <= delay_select_pin_i;
    end
  end

  // --------------------------------------------------------------------------
  // Control
  // --------------------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    assert_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = {CW{1'b0}};
        if (ready && pressed) begin
          if (hold_len(sel_r) == {CW{1'b0}}) begin
            state_nxt = ST_ASSERT;
            assert_nxt = 1'b1;
          end else begin
            state_nxt = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        if (!pressed) begin
          state_nxt = ST_IDLE;
          cnt_nxt = {CW{1'b0}};
        end else if (tick && cnt_r >= hold_len(sel_r) - 1'b1) begin
          state_nxt = ST_ASSERT;
          cnt_nxt = {CW{1'b0}};
          assert_nxt = 1'b1;
        end else if (tick) begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_ASSERT: begin
        if (IS_LEVEL) begin
          if (!pressed) begin
            state_nxt = ST_IDLE;
          end else begin
            assert_nxt = 1'b1;
          end
        end else if (tick && cnt_r >= PULSE_TK[CW-1:0] - 1'b1) begin
          // Inputs are only looked at once the pulse is over.
          state_nxt = ST_WAIT;
          cnt_nxt = {CW{1'b0}};
        end else begin
          assert_nxt = 1'b1;
          if (tick) begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
      end
      ST_WAIT: begin
        if (!pressed) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      cnt_r <= {CW{1'b0}};
      rst_out_n_o <= 1'b1;
      rst_out_oe_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      rst_out_n_o <= !assert_nxt;
      rst_out_oe_o <= assert_nxt;
    end
  end
endmodule // pbr_timer

/* tb/pbr_sys_model.sv */
// Pull-up on the system reset wire that the open-drain output drives.
`timescale 1ns/1ps
module pbr_sys_model (
  input wire rst_out_n_i,
  input wire rst_out_oe_i,
  output wire rst_line_o
);
  assign rst_line_o = rst_out_oe_i ? rst_out_n_i : 1'b1;
endmodule // pbr_sys_model

/* tb/pbr_timer_checker.sv */
// Concurrent checks on the reset timer ports.
`timescale 1ns/1ps
module pbr_timer_checker #(
  parameter [1:0] VARIANT = 2'h0,
  parameter TICK_CYC = 10, STARTUP_CYC = 20, HOLD_HI_TK = 5, HOLD_LO_TK = 3,
  parameter HOLD_PHI_TK = 0, PULSE_TK = 4
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire first_button_in_n_i,
  input wire second_button_in_n_i,
  input wire delay_select_pin_i,
  input wire rst_out_n_o,
  input wire rst_out_oe_o
);
  localparam int PL = PULSE_TK * TICK_CYC;
  int cnt_r, pc_r, oc_r, hl;
  logic sl_r;
  wire pr = (VARIANT == 2'h2) ? !first_button_in_n_i
                              : !(first_button_in_n_i | second_button_in_n_i);
  // The expected hold follows the select level the block may sample, not the live pin.
  always_comb hl = TICK_CYC *
      (sl_r ? (VARIANT == 2'h0 ? HOLD_HI_TK : HOLD_PHI_TK) : HOLD_LO_TK);
  // Press length counts only once start-up is over, as the block ignores buttons before.
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 0;
      pc_r <= 0;
      oc_r <= 0;
      sl_r <= 1'b0;
    end else begin
      cnt_r <= (cnt_r < STARTUP_CYC) ? cnt_r + 1 : cnt_r;
      pc_r <= (pr && cnt_r >= STARTUP_CYC) ? pc_r + 1 : 0;
      oc_r <= rst_out_oe_o ? oc_r + 1 : 0;
      if (cnt_r < STARTUP_CYC || !pr) begin
        sl_r <= delay_select_pin_i;
      end
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  property p_drive; rst_out_oe_o == !rst_out_n_o; endproperty
  a_drive: assert property (p_drive) else $error("drive and data disagree");
  property p_por; disable iff (1'b0) rst_i |-> !rst_out_oe_o && rst_out_n_o; endproperty
  a_por: assert property (p_por) else $error("output driven in reset");
  property p_startup; cnt_r < STARTUP_CYC |-> !rst_out_oe_o; endproperty
  a_startup: assert property (p_startup) else $error("assert before start-up");
  property p_hold; $rose(rst_out_oe_o) |-> pc_r >= hl - 1 && pc_r <= hl + 5; endproperty
  a_hold: assert property (p_hold) else $error("hold time wrong");
  property p_pulse; VARIANT != 2'h0 && $fell(rst_out_oe_o) |-> oc_r >= PL - 2 && oc_r <= PL + 2;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse length wrong");
  property p_pulse_min; VARIANT != 2'h0 && $rose(rst_out_oe_o) |-> rst_out_oe_o[*8]; endproperty
  a_pulse_min: assert property (p_pulse_min) else $error("pulse cut short");
  property p_level_off; VARIANT == 2'h0 && rst_out_oe_o && !pr |-> ##[1:2] !rst_out_oe_o;
  endproperty
  a_level_off: assert property (p_level_off) else $error("level not released");
  property p_level_on; VARIANT == 2'h0 && rst_out_oe_o && pr && $past(pr) |=> rst_out_oe_o;
  endproperty
  a_level_on: assert property (p_level_on) else $error("level dropped");
  c_assert: cover property ($rose(rst_out_oe_o));
  c_release: cover property ($fell(rst_out_oe_o));
  c_short: cover property (pr ##1 !pr);
endmodule // pbr_timer_checker
bind pbr_timer pbr_timer_checker #(.VARIANT(VARIANT), .TICK_CYC(TICK_CYC),
  .STARTUP_CYC(STARTUP_CYC), .HOLD_HI_TK(HOLD_HI_TK), .HOLD_LO_TK(HOLD_LO_TK),
  .HOLD_PHI_TK(HOLD_PHI_TK), .PULSE_TK(PULSE_TK)) u_chk (.sys_clk_i, .rst_i,
  .first_button_in_n_i, .second_button_in_n_i, .delay_select_pin_i, .rst_out_n_o,
  .rst_out_oe_o);

/* tb/tb.sv */
// Self-checking bench driving all three timer variants from shared buttons.
`timescale 1ns/1ps
`include "pbr_map.vh"
`define PBR_P .TICK_CYC(T_TICK), .STARTUP_CYC(T_START), .HOLD_HI_TK(T_HI), .HOLD_LO_TK(T_LO), \
  .HOLD_PHI_TK(T_PHI), .PULSE_TK(T_PULSE)
`define PBR_C .sys_clk_i(sys_clk_i), .rst_i(rst_i), .first_button_in_n_i(first_button_in_n_i), \
  .second_button_in_n_i(second_button_in_n_i), .delay_select_pin_i(delay_select_pin_i)
`define CHK(a, e) begin \
  n_checks++; \
  if ((a) !== (e)) begin \
    fail_count++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, e); \
  end \
end
module tb;
  localparam int T_TICK = 10;
  localparam int T_START = 20;
  localparam int T_HI = 5;
  localparam int T_LO = 3;
  localparam int T_PHI = 0;
  localparam int T_PULSE = 4;
  logic sys_clk_i = 0, rst_i = 0, first_button_in_n_i = 0, second_button_in_n_i = 0;
  logic delay_select_pin_i = 0;
  wire [2:0] oe;
  wire [2:0] od;
  wire rst_line;
  int fail_count = 0, n_checks = 0;
  // Rows: {first, second, select}, cycles to wait, {dual, level, single} drive.
  // Select moves only with a button up, except row 14 which tries a frozen change.
  logic [2:0] r_in [17] = '{3'h0, 3'h0, 3'h0, 3'h4, 3'h2, 3'h0, 3'h6, 3'h0, 3'h0, 3'h4, 3'h0,
    3'h0, 3'h7, 3'h1, 3'h0, 3'h6, 3'h0};
  int r_w [17] = '{40, 20, 40, 5, 40, 20, 5, 25, 15, 2, 10, 30, 5, 10, 35, 3, 40};
  logic [2:0] r_ex [17] = '{3'h0, 3'h7, 3'h2, 3'h0, 3'h1, 3'h1, 3'h1, 3'h0, 3'h6, 3'h4, 3'h4,
    3'h3, 3'h1, 3'h5, 3'h0, 3'h0, 3'h7};
  pbr_timer #(.VARIANT(`PBR_VAR_DUAL_PULSE), `PBR_P) u_dut (`PBR_C, .rst_out_n_o(od[2]),
    .rst_out_oe_o(oe[2]));
  pbr_timer #(.VARIANT(`PBR_VAR_LEVEL), `PBR_P) u_lvl (`PBR_C, .rst_out_n_o(od[1]),
    .rst_out_oe_o(oe[1]));
  pbr_timer #(.VARIANT(`PBR_VAR_SINGLE), `PBR_P) u_sgl (`PBR_C, .rst_out_n_o(od[0]),
    .rst_out_oe_o(oe[0]));
  pbr_sys_model u_sys (.rst_out_n_i(od[2]), .rst_out_oe_i(oe[2]), .rst_line_o(rst_line));
  initial forever #10 sys_clk_i = ~sys_clk_i;
  task run(input logic [2:0] in, input int w, input logic [2:0] ex);
    {first_button_in_n_i, second_button_in_n_i, delay_select_pin_i} = in;
    repeat (w) @(posedge sys_clk_i);
    #1;
    `CHK(oe, ex)
    `CHK(od, ~ex)
    `CHK(rst_line, ~ex[2])
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    fail_count++;
    end_of_test;
  end
  initial begin
    #1 rst_i = 1;
    repeat (20) @(posedge sys_clk_i);
    #1 rst_i = 0;
    for (int i = 0; i < 17; i++) run(r_in[i], r_w[i], r_ex[i]);
    // A second reset while every output is asserted and both buttons stay held.
    rst_i = 1;
    run(3'h0, 2, 3'h0);
    rst_i = 0;
    run(3'h0, 40, 3'h0);
    run(3'h0, 20, 3'h7);
    // Zero hold on the pulse variants and the long hold on the level variant.
    run(3'h7, 40, 3'h0);
    run(3'h1, 10, 3'h5);
    run(3'h1, 39, 3'h0);
    run(3'h1, 3, 3'h2);
    end_of_test;
  end
endmodule // tb
